//--- rtl/scsw_core.sv
// spi master/slave core with tx fifo, slave link domain and standby power control
`timescale 1ns/10ps
// What this block does
// - master drives eight slave selects, one at a time
// - serial clock driven in master, input in slave
// - master-in line input in master, driven in slave while selected
// - master-out line driven in master, input slave
// - interrupt request raised in both modes
// - standby and wake outputs only with wake enable
// - pll powers off after its clocks low
// - bandgap off cuts por, pll, osc, bank buffers
// - por off keeps limited detector active
// - oscillator and pll static or standby shutdown
// - referenced buffers switched off per bank
// - each primary clock net has own enable
// - input buffers gated, also during standby

// ****************************************
// tx fifo
// ****************************************
module scsw_fifo
    import scsw_pkg::*;
#(
    parameter int W = 8,
    parameter int D = 8
)(
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int PW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [PW-1:0]       wr;
        logic [PW-1:0]       rd;
        logic [PW:0]         cnt;
        logic                full;
        logic                empty;
    } scsw_fifo_type;
    scsw_fifo_type q, d;
    logic push, pop;

    assign in_ready  = ~q.full;
    assign out_valid = ~q.empty;
    assign out_data  = q.mem[q.rd];
    assign push      = in_valid & ~q.full;
    assign pop       = out_ready & ~q.empty;

    always_comb
    begin
        d = q;
        if (push)
        begin
            d.mem[q.wr] = in_data;
            d.wr = q.wr + PW'(1);
        end
        if (pop)
            d.rd = q.rd + PW'(1);
        d.cnt   = q.cnt + (PW+1)'(push) - (PW+1)'(pop);
        d.full  = d.cnt == (PW+1)'(D);
        d.empty = d.cnt == '0;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            q       <= '0;
            q.empty <= 1'b1;
        end
        else
            q <= d;
    end
endmodule : scsw_fifo

// ****************************************
// slave link, runs on the external serial clock
// ****************************************
module scsw_link
    import scsw_pkg::*;
(
    input  wire logic              link_clk,
    input  wire logic              link_nrst,
    input  wire logic              mosi_i,
    input  wire logic [WORD_W-1:0] tx_word,
    output logic                   miso_q,
    output logic [WORD_W-1:0]      rx_word_q,
    output logic                   tog_q
);
    typedef struct packed {
        logic [LINK_CNT_W-1:0] cnt;
        logic [WORD_W-2:0]     sh_rx;
        logic [WORD_W-2:0]     sh_tx;
        logic [WORD_W-1:0]     rx_word;
        logic                  tog;
        logic                  miso;
    } scsw_link_type;
    scsw_link_type q, d;

    assign miso_q    = q.miso;
    assign rx_word_q = q.rx_word;
    assign tog_q     = q.tog;

    always_comb
    begin
        d = q;
        d.cnt   = q.cnt + LINK_CNT_W'(1);
        d.sh_rx = {q.sh_rx[WORD_W-3:0], mosi_i};
        if (q.cnt == LINK_LAST)
        begin
            d.rx_word = {q.sh_rx, mosi_i};
            d.tog     = ~q.tog;
        end
        if (q.cnt == LINK_FIRST)
        begin
            d.miso  = tx_word[WORD_W-1];
            d.sh_tx = tx_word[WORD_W-2:0];
        end
        else
        begin
            d.miso  = q.sh_tx[WORD_W-2];
            d.sh_tx = {q.sh_tx[WORD_W-3:0], 1'b0};
        end
    end

    // frame end clears the link through its reset
    always_ff @(posedge link_clk or negedge link_nrst)
    begin
        if (!link_nrst)
            q <= '0;
        else
            q <= d;
    end
endmodule : scsw_link

// ****************************************
// top: master engine, slave crossing, power control
// ****************************************
module scsw_core
    import scsw_pkg::*;
(
    input  wire logic                core_clk,
    input  wire logic                nrst,
    input  wire logic                link_clk,
    input  wire logic                master_mode,
    input  wire logic [CS_SEL_W-1:0] cs_sel,
    input  wire logic                tx_valid,
    output logic                     tx_ready,
    input  wire logic [WORD_W-1:0]   tx_data,
    output logic                     rx_valid,
    output logic [WORD_W-1:0]        rx_data,
    output logic                     rx_flash,
    output logic                     irq,
    input  wire logic                irq_ack,
    output logic [NUM_CS-1:0]        cs_n,
    input  wire logic                slave_sel_n,
    input  wire logic                flash_slave_select,
    input  wire logic                sclk_i,
    output logic                     sclk_o,
    output logic                     sclk_oe_n,
    input  wire logic                miso_i,
    output logic                     miso_o,
    output logic                     miso_oe_n,
    input  wire logic                mosi_i,
    output logic                     mosi_o,
    output logic                     mosi_oe_n,
    input  wire logic                wake_en,
    input  wire logic                stdby_req,
    input  wire logic                wake_req,
    output logic                     stdby,
    output logic                     wake,
    input  wire logic                low_volt_part,
    input  wire logic                bg_off_cfg,
    input  wire logic                por_off_cfg,
    input  wire logic                osc_static_off,
    input  wire logic                osc_stdby_off,
    input  wire logic                pll_static_off,
    input  wire logic                pll_stdby_off,
    input  wire logic                pll_clks_low,
    input  wire logic [NUM_BANK-1:0] bank_buf_req,
    input  wire logic [NUM_PCLK-1:0] pclk_en_req,
    input  wire logic [NUM_IBUF-1:0] ibuf_req,
    input  wire logic [NUM_IBUF-1:0] ibuf_stdby_off,
    output logic                     bg_on,
    output logic                     por_on,
    output logic                     lpd_on,
    output logic                     osc_on,
    output logic                     pll_on,
    output logic [NUM_BANK-1:0]      bank_buf_en,
    output logic [NUM_PCLK-1:0]      pclk_en,
    output logic [NUM_IBUF-1:0]      ibuf_en
);
    typedef struct packed {
        logic                 busy;
        logic [BIT_CNT_W-1:0] cnt;
        logic [DIV_W-1:0]     div;
        logic                 sclk;
        logic [WORD_W-1:0]    sh_tx;
        logic [WORD_W-1:0]    sh_rx;
        logic                 mosi;
        logic [NUM_CS-1:0]    cs_n;
        logic                 sclk_oe_n;
        logic                 mosi_oe_n;
        logic                 miso_oe_n;
        logic [WORD_W-1:0]    rx_data;
        logic                 rx_valid;
        logic                 rx_flash;
        logic                 irq;
        logic                 miso_s1, miso_s2;
        logic                 sel_s1, sel_s2;
        logic                 fsel_s1, fsel_s2;
        logic                 tog_s1, tog_s2, tog_last;
        logic                 pll_s1, pll_s2;
        logic [WORD_W-1:0]    slv_tx;
        scsw_pwr_type         pwr;
        logic                 stdby, wake;
        logic                 bg_on, por_on, lpd_on, osc_on, pll_on;
        logic [NUM_BANK-1:0]  bank_buf_en;
        logic [NUM_PCLK-1:0]  pclk_en;
        logic [NUM_IBUF-1:0]  ibuf_en;
    } scsw_core_type;
    scsw_core_type q, d;

    logic              fifo_ov, pop;
    logic [WORD_W-1:0] fifo_od;
    logic              link_nrst, link_miso, link_tog;
    logic [WORD_W-1:0] link_rx;
    logic              st, bg_cut, pll_off_want;

    function automatic logic [NUM_CS-1:0] cs_decode(input logic [CS_SEL_W-1:0] sel);
        cs_decode = ~(CS_ONE << sel);
    endfunction : cs_decode

    scsw_fifo #(.W(WORD_W), .D(FIFO_DEPTH)) u_fifo (
        .clk       (core_clk),
        .nrst      (nrst),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .in_data   (tx_data),
        .out_valid (fifo_ov),
        .out_ready (pop),
        .out_data  (fifo_od)
    );

    // link held in reset outside a slave frame
    assign link_nrst = nrst & ~master_mode & ~(slave_sel_n & flash_slave_select);

    scsw_link u_link (
        .link_clk  (link_clk),
        .link_nrst (link_nrst),
        .mosi_i    (mosi_i),
        .tx_word   (q.slv_tx),
        .miso_q    (link_miso),
        .rx_word_q (link_rx),
        .tog_q     (link_tog)
    );

    assign st     = q.pwr == PWR_STDBY;
    assign bg_cut = bg_off_cfg & low_volt_part;
    assign pll_off_want = pll_static_off | ((q.pwr != PWR_RUN) & (pll_stdby_off | bg_cut));

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        d = q;
        pop = 1'b0;
        d.rx_valid = 1'b0;
        d.wake     = 1'b0;
        d.miso_s1  = miso_i;
        d.miso_s2  = q.miso_s1;
        d.sel_s1   = ~slave_sel_n;
        d.sel_s2   = q.sel_s1;
        d.fsel_s1  = ~flash_slave_select;
        d.fsel_s2  = q.fsel_s1;
        d.tog_s1   = link_tog;
        d.tog_s2   = q.tog_s1;
        d.tog_last = q.tog_s2;
        d.pll_s1   = pll_clks_low;
        d.pll_s2   = q.pll_s1;
        d.sclk_oe_n = ~master_mode;
        d.mosi_oe_n = ~master_mode;
        d.miso_oe_n = ~(~master_mode & (q.sel_s2 | q.fsel_s2));
        if (irq_ack)
            d.irq = 1'b0;
        if (!q.busy)
        begin
            if (master_mode & fifo_ov)
            begin
                pop     = 1'b1;
                d.busy  = 1'b1;
                d.sh_tx = fifo_od;
                d.mosi  = fifo_od[WORD_W-1];
                d.cs_n  = cs_decode(cs_sel);
                d.div   = '0;
                d.cnt   = '0;
                d.sclk  = 1'b0;
            end
            else if (!master_mode & (q.sel_s2 | q.fsel_s2) & (q.tog_s2 != q.tog_last))
            begin
                d.rx_data  = link_rx;
                d.rx_valid = 1'b1;
                d.rx_flash = q.fsel_s2;
                d.irq      = 1'b1;
                pop        = fifo_ov;
                d.slv_tx   = fifo_ov ? fifo_od : SLV_FILL;
            end
        end
        else if (q.div == DIV_LAST)
        begin
            d.div  = '0;
            d.sclk = ~q.sclk;
            if (!q.sclk)
                d.sh_rx = {q.sh_rx[WORD_W-2:0], q.miso_s2};
            else
            begin
                d.sh_tx = {q.sh_tx[WORD_W-2:0], 1'b0};
                d.mosi  = q.sh_tx[WORD_W-2];
                d.cnt   = q.cnt + BIT_CNT_W'(1);
                if (q.cnt == BYTE_LAST)
                begin
                    d.busy     = 1'b0;
                    d.cs_n     = CS_IDLE;
                    d.rx_data  = q.sh_rx;
                    d.rx_valid = 1'b1;
                    d.rx_flash = 1'b0;
                    d.irq      = 1'b1;
                end
            end
        end
        else
            d.div = q.div + DIV_W'(1);

        // power sequencing
        case (q.pwr)
            PWR_RUN:
                if (stdby_req)
                    d.pwr = PWR_DRAIN;
            PWR_DRAIN:
                if (!stdby_req)
                    d.pwr = PWR_RUN;
                else if (!pll_off_want | !q.pll_on)
                    d.pwr = PWR_STDBY;
            PWR_STDBY:
                if (!stdby_req | wake_req)
                begin
                    d.pwr  = PWR_RUN;
                    d.wake = wake_en;
                end
            default:
                d.pwr = PWR_RUN;
        endcase
        if (!pll_off_want)
            d.pll_on = 1'b1;
        else if (q.pll_s2)
            d.pll_on = 1'b0;
        d.stdby  = wake_en & (d.pwr == PWR_STDBY);
        d.bg_on  = ~(st & bg_cut & ~q.pll_on);
        d.por_on = ~(st & (bg_cut | por_off_cfg));
        d.lpd_on = st & (bg_cut | por_off_cfg);
        d.osc_on = ~(osc_static_off | (st & (osc_stdby_off | bg_cut)));
        d.bank_buf_en = bank_buf_req & ~{NUM_BANK{st & bg_cut}};
        d.pclk_en = pclk_en_req;
        d.ibuf_en = ibuf_req & ~({NUM_IBUF{st}} & ibuf_stdby_off);
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            q           <= '0;
            q.cs_n      <= CS_IDLE;
            q.sclk_oe_n <= 1'b1;
            q.mosi_oe_n <= 1'b1;
            q.miso_oe_n <= 1'b1;
            q.pwr       <= PWR_RUN;
            q.bg_on     <= 1'b1;
            q.por_on    <= 1'b1;
            q.osc_on    <= 1'b1;
            q.pll_on    <= 1'b1;
        end
        else
            q <= d;
    end

    assign cs_n        = q.cs_n;
    assign sclk_o      = q.sclk;
    assign sclk_oe_n   = q.sclk_oe_n;
    assign mosi_o      = q.mosi;
    assign mosi_oe_n   = q.mosi_oe_n;
    assign miso_o      = link_miso;
    assign miso_oe_n   = q.miso_oe_n;
    assign rx_valid    = q.rx_valid;
    assign rx_data     = q.rx_data;
    assign rx_flash    = q.rx_flash;
    assign irq         = q.irq;
    assign stdby       = q.stdby;
    assign wake        = q.wake;
    assign bg_on       = q.bg_on;
    assign por_on      = q.por_on;
    assign lpd_on      = q.lpd_on;
    assign osc_on      = q.osc_on;
    assign pll_on      = q.pll_on;
    assign bank_buf_en = q.bank_buf_en;
    assign pclk_en     = q.pclk_en;
    assign ibuf_en     = q.ibuf_en;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence s_byte_start;
        !q.busy ##1 q.busy;
    endsequence
    sequence s_byte_done;
        q.rx_valid && q.cs_n == CS_IDLE;
    endsequence

    a_cs_one_low: assert property ($countones(~cs_n) <= 1)
        else $error("more than one slave select low");
    a_sclk_dir: assert property (sclk_oe_n == !$past(master_mode))
        else $error("clock pin direction wrong");
    a_miso_dir: assert property (!miso_oe_n |-> !$past(master_mode))
        else $error("master-in driven in master mode");
    a_mosi_dir: assert property (!mosi_oe_n |-> $past(master_mode))
        else $error("master-out driven in slave mode");
    a_pins_excl: assert property (!(!miso_oe_n && !mosi_oe_n))
        else $error("both data pins driven");
    a_irq_on_byte: assert property (rx_valid |-> irq ##1 (irq || $past(irq_ack)))
        else $error("byte without interrupt");
    a_master_byte: assert property (s_byte_start |-> ##[63:65] s_byte_done)
        else $error("master byte length wrong");
    a_wake_gate: assert property (!$past(wake_en) |-> !stdby && !wake)
        else $error("standby or wake without enable");
    a_pll_drain: assert property ($fell(pll_on) |-> $past(q.pll_s2))
        else $error("pll off before clocks low");
    a_bg_chain: assert property (!bg_on |-> !por_on && !osc_on && !pll_on && bank_buf_en == '0)
        else $error("bandgap off with analog on");
    a_lpd_keep: assert property (!por_on |-> lpd_on)
        else $error("por off without detector");
    a_ibuf_gate: assert property (ibuf_en == ($past(ibuf_req) & ~({NUM_IBUF{$past(st)}} & $past(ibuf_stdby_off))))
        else $error("input buffer gate wrong");
endmodule : scsw_core

//--- rtl/scsw_pkg.sv
// shared constants and types for the spi core with standby and wake control
package scsw_pkg;
    localparam int WORD_W       = 8;
    localparam int FIFO_DEPTH   = 8;
    localparam int NUM_CS       = 8;
    localparam int CS_SEL_W     = 3;
    localparam int NUM_BANK     = 6;
    localparam int NUM_PCLK     = 8;
    localparam int NUM_IBUF     = 8;
    localparam int BIT_CNT_W    = 4;
    localparam int DIV_W        = 4;
    localparam int LINK_CNT_W   = 3;
    // timing of the master serial clock
    localparam int CORE_CLK_NS  = 25;
    localparam int SCLK_HALF_NS = 100;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
    localparam logic [DIV_W-1:0]      DIV_LAST   = DIV_W'(SCLK_HALF_CYC - 1);
    localparam logic [BIT_CNT_W-1:0]  BYTE_LAST  = BIT_CNT_W'(WORD_W - 1);
    localparam logic [LINK_CNT_W-1:0] LINK_FIRST = 3'h0;
    localparam logic [LINK_CNT_W-1:0] LINK_LAST  = 3'h7;
    // reset, idle and decode values
    localparam logic [WORD_W-1:0]     SLV_FILL   = 8'h00;
    localparam logic [NUM_CS-1:0]     CS_IDLE    = 8'hff;
    localparam logic [NUM_CS-1:0]     CS_ONE     = 8'h01;
    typedef enum logic [1:0] {PWR_RUN, PWR_DRAIN, PWR_STDBY} scsw_pwr_type;
endpackage : scsw_pkg

//--- tb/scsw_spi_peer.sv
// behavioural spi peer: slave in master mode, master in slave mode
`timescale 1ns/10ps
// ****
// peer
// ****
module scsw_spi_peer
    import scsw_pkg::*;
(
    input  wire logic              sclk_w,
    input  wire logic              miso_w,
    input  wire logic              mosi_w,
    input  wire logic [NUM_CS-1:0] cs_n,
    input  wire logic [WORD_W-1:0] reply,
    output logic                   p_sclk,
    output logic                   p_mosi,
    output logic                   p_mosi_oe,
    output logic                   p_miso,
    output logic                   p_sel_n,
    output logic                   p_flash_n,
    output logic [WORD_W-1:0]      rx_seen,
    output logic [WORD_W-1:0]      miso_seen
);
    logic [WORD_W-1:0] sh;
    initial
    begin
        p_sclk = 1'b0;
        p_mosi = 1'b0;
        p_mosi_oe = 1'b0;
        p_sel_n = 1'b1;
        p_flash_n = 1'b1;
    end
    // slave side: reply loaded on select, shifted after falling clock
    always @(cs_n)
        if (cs_n != CS_IDLE)
            sh = reply;
    always @(negedge sclk_w)
        if (cs_n != CS_IDLE)
            sh = sh << 1;
    assign p_miso = sh[WORD_W-1];
    always @(posedge sclk_w)
        rx_seen <= {rx_seen[WORD_W-2:0], mosi_w};
    // master side: clock stands low outside frames
    task automatic send(input logic [WORD_W-1:0] b, input logic fl);
        int i;
        if (fl)
            p_flash_n = 1'b0;
        else
            p_sel_n = 1'b0;
        p_mosi_oe = 1'b1;
        #160;
        for (i = 0; i < WORD_W; i++)
        begin
            p_mosi = b[WORD_W-1-i];
            #80 p_sclk = 1'b1;
            #80 p_sclk = 1'b0;
            miso_seen = {miso_seen[WORD_W-2:0], miso_w};
        end
        #200 p_sel_n = 1'b1;
        p_flash_n = 1'b1;
        p_mosi_oe = 1'b0;
        #200;
    endtask : send
endmodule : scsw_spi_peer

//--- tb/scsw_core_tb.sv
// self-checking bench for the spi core with standby and wake control
`timescale 1ns/10ps
// ****
// bench
// ****
module scsw_core_tb
    import scsw_pkg::*;
;
    logic core_clk = 1'b0, nrst = 1'b0, undr = 1'b0;
    logic master_mode, tx_valid, irq_ack, wake_en, stdby_req, wake_req, low_volt_part, bg_off_cfg, por_off_cfg;
    logic osc_static_off, osc_stdby_off, pll_static_off, pll_stdby_off, pll_clks_low;
    logic [CS_SEL_W-1:0] cs_sel;
    logic [WORD_W-1:0]   tx_data, reply, rx_data, rx_seen, miso_seen;
    logic [NUM_BANK-1:0] bank_buf_req, bank_buf_en;
    logic [NUM_PCLK-1:0] pclk_en_req, pclk_en;
    logic [NUM_IBUF-1:0] ibuf_req, ibuf_stdby_off, ibuf_en;
    logic [NUM_CS-1:0]   cs_n;
    logic tx_ready, rx_valid, rx_flash, irq, sclk_o, sclk_oe_n, miso_o, miso_oe_n, mosi_o, mosi_oe_n;
    logic stdby, wake, bg_on, por_on, lpd_on, osc_on, pll_on, p_sclk, p_mosi, p_mosi_oe, p_miso, p_sel_n, p_flash_n;
    logic [WORD_W-1:0]   exp_rx[$], exp_tx[$];
    logic                exp_fl[$];
    logic [31:0]         seed = 32'ha119;
    int                  n_mismatch = 0, comparisons = 0, n_rx = 0;
    // released lines show a changing pattern
    wire sclk_w = !sclk_oe_n ? sclk_o : p_sclk;
    wire mosi_w = !mosi_oe_n ? mosi_o : (p_mosi_oe ? p_mosi : undr);
    wire miso_w = !miso_oe_n ? miso_o : (cs_n != CS_IDLE ? p_miso : undr);
    always #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) undr <= ~undr;
    scsw_core u_dut (.core_clk, .nrst, .link_clk(sclk_w), .master_mode, .cs_sel, .tx_valid, .tx_ready, .tx_data,
        .rx_valid, .rx_data, .rx_flash, .irq, .irq_ack, .cs_n, .slave_sel_n(p_sel_n), .flash_slave_select(p_flash_n),
        .sclk_i(sclk_w), .sclk_o, .sclk_oe_n, .miso_i(miso_w), .miso_o, .miso_oe_n, .mosi_i(mosi_w), .mosi_o,
        .mosi_oe_n, .wake_en, .stdby_req, .wake_req, .stdby, .wake, .low_volt_part, .bg_off_cfg, .por_off_cfg,
        .osc_static_off, .osc_stdby_off, .pll_static_off, .pll_stdby_off, .pll_clks_low, .bank_buf_req,
        .pclk_en_req, .ibuf_req, .ibuf_stdby_off, .bg_on, .por_on, .lpd_on, .osc_on, .pll_on, .bank_buf_en,
        .pclk_en, .ibuf_en);
    scsw_spi_peer u_peer (.sclk_w, .miso_w, .mosi_w, .cs_n, .reply, .p_sclk, .p_mosi, .p_mosi_oe, .p_miso,
        .p_sel_n, .p_flash_n, .rx_seen, .miso_seen);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic tmo(input logic ok);
        if (!ok)
        begin
            n_mismatch++;
            finish_test();
        end
    endtask : tmo
    // every received byte against the model queues
    always @(negedge core_clk)
        if (rx_valid === 1'b1)
        begin
            chk(rx_data, exp_rx.pop_front());
            chk(rx_flash, exp_fl.pop_front());
            chk(irq, 1'b1);
            if (master_mode)
                chk(rx_seen, exp_tx.pop_front());
            n_rx++;
        end
    task automatic master_burst(input int n);
        int i, k;
        for (k = 0; k < n; k++)
        begin
            for (i = 0; i < 200 && cs_n === CS_IDLE; i++)
                @(negedge core_clk);
            tmo(i < 200);
            chk(cs_n, 8'(~(CS_ONE << cs_sel)));
            chk({sclk_oe_n, mosi_oe_n, miso_oe_n}, 3'h1);
            exp_rx.push_back(reply);
            exp_fl.push_back(1'b0);
            @(posedge core_clk);
            seed = lfsr(seed);
            cs_sel <= seed[2:0];
            reply <= seed[15:8];
            for (i = 0; i < 200 && cs_n !== CS_IDLE; i++)
                @(negedge core_clk);
            tmo(i < 200);
        end
    endtask : master_burst
    initial
    begin
        int i;
        {master_mode, tx_valid, irq_ack, wake_en, stdby_req, wake_req, low_volt_part, bg_off_cfg} = 8'h00;
        {por_off_cfg, osc_static_off, osc_stdby_off, pll_static_off, pll_stdby_off, pll_clks_low} = 6'h00;
        {cs_sel, tx_data, reply} = 19'h0;
        {bank_buf_req, pclk_en_req, ibuf_req, ibuf_stdby_off} = 30'h0;
        repeat (3) @(posedge core_clk);
        chk({cs_n, sclk_oe_n, mosi_oe_n, miso_oe_n, rx_valid, irq, stdby, wake, bg_on, por_on, osc_on, pll_on,
            lpd_on}, 20'hffe1e);
        chk({bank_buf_en, pclk_en, ibuf_en}, 22'h0);
        nrst <= 1'b1;
        for (i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            {bank_buf_req, pclk_en_req, ibuf_req} <= seed[21:0];
            ibuf_stdby_off <= seed[29:22];
            repeat (3) @(posedge core_clk);
            chk({bank_buf_en, pclk_en, ibuf_en}, {bank_buf_req, pclk_en_req, ibuf_req});
        end
        chk({sclk_oe_n, mosi_oe_n, miso_oe_n}, 3'h7);
        for (i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            exp_rx.push_back(seed[7:0]);
            exp_fl.push_back(i[0]);
            #(3 + i);
            u_peer.send(seed[7:0], i[0]);
            chk(miso_seen, 8'h00);
        end
        @(posedge core_clk);
        irq_ack <= 1'b1;
        @(posedge core_clk);
        irq_ack <= 1'b0;
        @(negedge core_clk);
        chk(irq, 1'b0);
        // fill the fifo until it refuses
        @(posedge core_clk);
        tx_valid <= 1'b1;
        for (i = 0; i < 12; i++)
        begin
            seed = lfsr(seed);
            tx_data <= seed[7:0];
            @(posedge core_clk);
            if (tx_ready === 1'b1)
                exp_tx.push_back(tx_data);
        end
        tx_valid <= 1'b0;
        chk(exp_tx.size(), FIFO_DEPTH);
        master_mode <= 1'b1;
        master_burst(FIFO_DEPTH);
        @(posedge core_clk);
        master_mode <= 1'b0;
        chk(tx_ready, 1'b1);
        chk(n_rx, 12);
        // standby with wake enabled, pll held until its clocks are low
        {wake_en, low_volt_part, bg_off_cfg, osc_stdby_off, pll_stdby_off, stdby_req} <= 6'h3f;
        repeat (10) @(posedge core_clk);
        chk({stdby, pll_on}, 2'h1);
        pll_clks_low <= 1'b1;
        for (i = 0; i < 40 && stdby !== 1'b1; i++)
            @(posedge core_clk);
        tmo(i < 40);
        repeat (3) @(posedge core_clk);
        chk({pll_on, bg_on, por_on, osc_on, lpd_on, bank_buf_en}, 11'h040);
        chk(ibuf_en, ibuf_req & ~ibuf_stdby_off);
        stdby_req <= 1'b0;
        wake_req <= 1'b1;
        for (i = 0; i < 40 && wake !== 1'b1; i++)
            @(posedge core_clk);
        tmo(i < 40);
        wake_req <= 1'b0;
        // standby without wake option on a part that keeps its bandgap
        {wake_en, low_volt_part, por_off_cfg, stdby_req} <= 4'h3;
        repeat (12) @(posedge core_clk);
        chk({stdby, bg_on, por_on, lpd_on}, 4'h5);
        stdby_req <= 1'b0;
        for (i = 0; i < 10; i++)
        begin
            @(posedge core_clk);
            chk(wake, 1'b0);
        end
        {osc_static_off, pll_static_off} <= 2'h3;
        repeat (6) @(posedge core_clk);
        chk({osc_on, pll_on}, 2'h0);
        finish_test();
    end
endmodule : scsw_core_tb
